// ### design/tsc_pkg.sv
// package: register map, descriptor layout, timing and carrier types of the channel
package tsc_pkg;
	// --------------------------------------------------------------
	// register map (byte addresses)
	// --------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_CMD     = 12'h004;
	localparam logic [11:0] OFS_EVENT   = 12'h008;
	localparam logic [11:0] OFS_STATUS  = 12'h00c;
	localparam logic [11:0] OFS_TX_BASE = 12'h010;
	localparam logic [11:0] OFS_RX_BASE = 12'h014;
	localparam logic [11:0] OFS_MAX_RX  = 12'h018;
	localparam logic [11:0] OFS_ZERO    = 12'h030;
	// control bits
	localparam int CTL_TX_EN  = 0;
	localparam int CTL_RX_EN  = 1;
	localparam int CTL_REV    = 2;
	localparam int CTL_DIRECT = 3;
	// command bits, self clearing
	localparam int CMD_STOP    = 0;
	localparam int CMD_RESTART = 1;
	localparam int CMD_HUNT    = 2;
	// event bits, write one to clear
	localparam int EV_TXB  = 0;
	localparam int EV_TXE  = 1;
	localparam int EV_RXB  = 2;
	localparam int EV_BSY  = 3;
	localparam int EV_LINE = 4;
	// reset values
	localparam logic [3:0]  CTRL_RST   = 4'h0;
	localparam logic [15:0] MAX_RX_RST = 16'h0002;
	// --------------------------------------------------------------
	// descriptor layout: status, length, pointer words
	// --------------------------------------------------------------
	localparam int D_RDY  = 15;
	localparam int D_WRAP = 13;
	localparam int D_INT  = 12;
	localparam int D_LAST = 11;
	localparam int D_FLT  = 9;
	localparam logic [31:0] DSC_LEN = 32'h0000_0002;
	localparam logic [31:0] DSC_PTR = 32'h0000_0004;
	// --------------------------------------------------------------
	// timing and storage
	// --------------------------------------------------------------
	localparam logic [3:0] POLL_LAST = 4'hf;
	localparam logic [3:0] TXF_BYTES = 4'h8;
	localparam logic [1:0] RXF_WORDS = 2'h3;
	// --------------------------------------------------------------
	// carrier types
	// --------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        we;
		logic [31:0] addr;
		logic [15:0] wdata;
	} tsc_mem_req_t;
	typedef struct packed {
		logic        ack;
		logic        full;
		logic [15:0] rdata;
	} tsc_mem_rsp_t;
	typedef enum logic [3:0] {
		TXS_OFF, TXS_POLL, TXS_STAT, TXS_LEN, TXS_PTR, TXS_FETCH,
		TXS_CLOSE, TXS_DRAIN, TXS_STOPPED, TXS_FAULT
	} tsc_tx_state_t;
	typedef enum logic [2:0] {
		RXS_OFF, RXS_HUNT, RXS_STAT, RXS_PTR, RXS_RUN, RXS_BUSY, RXS_LEN, RXS_CLOSE
	} tsc_rx_state_t;
endpackage

// ### design/tsc_channel.sv
// transparent serial channel: axi4-lite registers, descriptor engines, serial shifters
// ------------------------------------------------------------------
// Summary of operation
// - data passes bit for bit, no flags, stuffing or other processing
// - direct mode: serial output comes straight from the shift flop
// - enabled transmitter sends ones and polls descriptor every 16 tx clocks
// - sending starts only after fifo preload and, in slot mode, sync
// - buffer without last flag chains to next descriptor with no gap
// - next buffer late in continuous sending is underrun, sets tx fault event
// - after last buffer send ones; slot mode waits for sync again
// - any byte count at any start address; whole words fetched, extras dropped
// - bit reverse setting flips bit order of every sent and received byte
// - interrupt flag in descriptor sets tx buffer event after a buffer closed without underrun
// - enabled receiver hunts; in slot mode it waits for sync
// - receiver stores only 16-bit words, up to maximum receive length
// - full receive buffer closes and reception moves to next descriptor
// - no room in receive chunk sets the chunk full event
// - direct mode: first word stored only after sixteenth receive clock
// - after overrun in slot mode receiver stops until sync is found again; after busy it waits for the hunt command
// - errors are reported in descriptor status fields
// - line state shown in status register, each change raises an event
// - stop command drains the fifo, up to four words, then aborts buffer
// - stop command leaves the current descriptor index unchanged
// - after stop send ones until the restart command
// - restart command polls the descriptor at the current index
// - hunt command closes current buffer, hunts, continues with next descriptor
// - overrun of three-word fifo overwrites last word, closes with flag, hunts
// - slot modes align bytes and words to the slot sync edge
// ------------------------------------------------------------------
module tsc_channel
	import tsc_pkg::*;
#(
	parameter int unsigned IDX_W = 8
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [11:0]  s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [11:0]  s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         tx_clk,
	input  wire logic         rx_clk,
	input  wire logic         rxd,
	input  wire logic         slot_sync,
	output logic              txd,
	output tsc_mem_req_t      tx_mem_req,
	input  wire tsc_mem_rsp_t tx_mem_rsp,
	output tsc_mem_req_t      rx_mem_req,
	input  wire tsc_mem_rsp_t rx_mem_rsp
);
	function automatic logic [7:0] rev8(input logic [7:0] b, input logic on);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = b[7 - i];
		return on ? r : b;
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		for (int i = 0; i < 4; i++) r[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
		return r;
	endfunction
	function automatic logic [1:0] inc3(input logic [1:0] p);
		return (p == RXF_WORDS - 2'h1) ? 2'h0 : p + 2'h1;
	endfunction

	// ------------------------------------------------------------------
	// pin sampling: three flops, a change counts when stages two and three agree
	// ------------------------------------------------------------------
	logic [3:0] s1_q, s2_q, s3_q, lv_q;
	wire  [3:0] lv_d = (s2_q & s3_q) | (lv_q & (s2_q ^ s3_q));
	wire  [3:0] rise = lv_d & ~lv_q;
	wire        tx_tick = rise[0];
	wire        rx_tick = rise[1];
	wire        rx_bit = lv_q[2];
	wire        sync_rise = rise[3];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			s3_q <= 4'h0;
			lv_q <= 4'h0;
		end else begin
			s1_q <= {slot_sync, rxd, rx_clk, tx_clk};
			s2_q <= s1_q;
			s3_q <= s2_q;
			lv_q <= lv_d;
		end
	end

	// ------------------------------------------------------------------
	// register file
	// ------------------------------------------------------------------
	logic [3:0]  ctrl_q;
	logic [2:0]  cmd_q;
	logic [4:0]  ev_q;
	logic [31:0] tx_base_q, rx_base_q;
	logic [15:0] max_rx_q, zero_q;
	logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q, rdata_q;
	logic [3:0]  w_strb_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [1:0]  tx_ev_q, rx_ev_q;
	tsc_tx_state_t tx_st_q;
	tsc_rx_state_t rx_st_q;
	logic [IDX_W-1:0] tx_idx_q, rx_idx_q;
	logic        tx_go_q, rx_on_q;

	wire direct = ctrl_q[CTL_DIRECT];
	wire rev = ctrl_q[CTL_REV];
	wire wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
	wire hit_ctrl = aw_addr_q == OFS_CTRL;
	wire hit_cmd = aw_addr_q == OFS_CMD;
	wire hit_ev = aw_addr_q == OFS_EVENT;
	wire hit_txb = aw_addr_q == OFS_TX_BASE;
	wire hit_rxb = aw_addr_q == OFS_RX_BASE;
	wire hit_max = aw_addr_q == OFS_MAX_RX;
	wire hit_zero = aw_addr_q == OFS_ZERO;
	wire wr_ok = hit_ctrl | hit_cmd | hit_ev | hit_txb | hit_rxb | hit_max | hit_zero
		| (aw_addr_q == OFS_STATUS);
	wire [31:0] wv = w_data_q;
	wire [4:0]  ev_clr = (wr_go && hit_ev && w_strb_q[0]) ? wv[4:0] : 5'h0;
	wire        line_chg = lv_d[2] ^ lv_q[2];
	wire [4:0]  ev_set = {line_chg, rx_ev_q, tx_ev_q};
	wire [31:0] status = 32'({tx_idx_q, 4'h0, tx_go_q, rx_on_q, tx_st_q != TXS_OFF, lv_q[2]});
	wire [11:0] ra = s_axi_araddr;
	wire        rd_ok = ra == OFS_CTRL || ra == OFS_CMD || ra == OFS_EVENT || ra == OFS_STATUS
		|| ra == OFS_TX_BASE || ra == OFS_RX_BASE || ra == OFS_MAX_RX || ra == OFS_ZERO;
	wire [31:0] rd_word = (ra == OFS_CTRL) ? {28'h0, ctrl_q} :
		(ra == OFS_EVENT) ? {27'h0, ev_q} :
		(ra == OFS_STATUS) ? status :
		(ra == OFS_TX_BASE) ? tx_base_q :
		(ra == OFS_RX_BASE) ? rx_base_q :
		(ra == OFS_MAX_RX) ? {16'h0, max_rx_q} :
		(ra == OFS_ZERO) ? {16'h0, zero_q} : 32'h0;

	assign s_axi_awready = ~aw_hold_q;
	assign s_axi_wready = ~w_hold_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 12'h0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
		end else begin
			if (s_axi_awvalid && !aw_hold_q) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr & 12'hffc;
			end
			if (s_axi_wvalid && !w_hold_q) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? 2'h0 : 2'h3;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= 2'h0;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_ok ? rd_word : 32'h0;
			rresp_q <= rd_ok ? 2'h0 : 2'h3;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
			cmd_q <= 3'h0;
			ev_q <= 5'h0;
			tx_base_q <= 32'h0;
			rx_base_q <= 32'h0;
			max_rx_q <= MAX_RX_RST;
			zero_q <= 16'h0;
		end else begin
			// set beats clear so an event in the clearing cycle survives
			ev_q <= (ev_q & ~ev_clr) | ev_set;
			cmd_q <= (wr_go && hit_cmd && w_strb_q[0]) ? wv[2:0] : 3'h0;
			if (wr_go && hit_ctrl) ctrl_q <= 4'(merge({28'h0, ctrl_q}, wv, w_strb_q));
			if (wr_go && hit_txb) tx_base_q <= merge(tx_base_q, wv, w_strb_q);
			if (wr_go && hit_rxb) rx_base_q <= merge(rx_base_q, wv, w_strb_q);
			if (wr_go && hit_max) max_rx_q <= 16'(merge({16'h0, max_rx_q}, wv, w_strb_q));
			if (wr_go && hit_zero) zero_q <= 16'(merge({16'h0, zero_q}, wv, w_strb_q));
		end
	end

	// ------------------------------------------------------------------
	// transmitter: descriptor engine, byte fifo of four words, shifter
	// ------------------------------------------------------------------
	tsc_mem_req_t tx_req_q;
	logic [15:0] tx_stat_q, tx_len_q;
	logic [31:0] tx_addr_q;
	logic        tx_stop_q, tx_un_q, poll_due_q;
	logic [3:0]  poll_q, txf_cnt_q;
	logic [7:0]  txf_q [TXF_BYTES];
	logic [2:0]  txf_wp_q, txf_rp_q, tx_bit_q;
	logic [7:0]  tx_sh_q;

	wire [31:0] tx_dsc = tx_base_q + 32'({tx_idx_q, 3'b000});
	wire        tx_ack = tx_req_q.valid & tx_mem_rsp.ack;
	wire        tx_bnd = tx_tick & (tx_bit_q == 3'h0);
	wire        tx_pop = tx_bnd & tx_go_q & (txf_cnt_q != 4'h0);
	wire        tx_under = tx_bnd & tx_go_q & (txf_cnt_q == 4'h0) & (tx_st_q != TXS_DRAIN);
	wire        tx_fack = tx_ack & (tx_st_q == TXS_FETCH);
	wire        tx_one = tx_addr_q[0] | (tx_len_q == 16'h1);
	wire [1:0]  tx_npush = !tx_fack ? 2'h0 : tx_one ? 2'h1 : 2'h2;
	wire [7:0]  tx_b0 = tx_addr_q[0] ? tx_mem_rsp.rdata[7:0] : tx_mem_rsp.rdata[15:8];
	wire        tx_pre = (txf_cnt_q >= TXF_BYTES - 4'h1) | (tx_len_q == 16'h0);
	wire        tx_live = tx_st_q == TXS_FETCH || tx_st_q == TXS_CLOSE || tx_st_q == TXS_DRAIN;
	wire        tx_room = txf_cnt_q <= TXF_BYTES - 4'h2;

	assign tx_mem_req = tx_req_q;
	assign txd = tx_sh_q[7];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_sh_q <= 8'hff;
			tx_bit_q <= 3'h0;
			txf_cnt_q <= 4'h0;
			txf_wp_q <= 3'h0;
			txf_rp_q <= 3'h0;
			poll_q <= 4'h0;
			for (int i = 0; i < TXF_BYTES; i++) txf_q[i] <= 8'hff;
		end else begin
			if (tx_tick) poll_q <= poll_q + 4'h1;
			if (tx_pop) begin
				tx_sh_q <= rev8(txf_q[txf_rp_q], rev);
				tx_bit_q <= 3'h7;
				txf_rp_q <= txf_rp_q + 3'h1;
			end else if (tx_bnd) begin
				tx_sh_q <= 8'hff;
			end else if (tx_tick) begin
				tx_sh_q <= {tx_sh_q[6:0], 1'b1};
				tx_bit_q <= tx_bit_q - 3'h1;
			end
			if (tx_fack) begin
				txf_q[txf_wp_q] <= tx_b0;
				if (!tx_one) txf_q[txf_wp_q + 3'h1] <= tx_mem_rsp.rdata[7:0];
				txf_wp_q <= txf_wp_q + 3'(tx_npush);
			end
			txf_cnt_q <= txf_cnt_q + 4'(tx_npush) - 4'(tx_pop);
			if (tx_st_q == TXS_OFF) begin
				txf_cnt_q <= 4'h0;
				txf_rp_q <= txf_wp_q;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_st_q <= TXS_OFF;
			tx_req_q <= '0;
			tx_idx_q <= '0;
			tx_stat_q <= 16'h0;
			tx_len_q <= 16'h0;
			tx_addr_q <= 32'h0;
			tx_go_q <= 1'b0;
			tx_stop_q <= 1'b0;
			tx_un_q <= 1'b0;
			tx_ev_q <= 2'h0;
			poll_due_q <= 1'b0;
		end else begin
			tx_ev_q <= 2'h0;
			if (tx_tick && poll_q == POLL_LAST) poll_due_q <= 1'b1;
			if (cmd_q[CMD_STOP] && tx_st_q != TXS_OFF && tx_st_q != TXS_FAULT)
				tx_stop_q <= 1'b1;
			if (!tx_go_q && tx_live && tx_pre && !tx_stop_q && (direct || sync_rise))
				tx_go_q <= 1'b1;
			if (tx_under) begin
				tx_go_q <= 1'b0;
				tx_un_q <= 1'b1;
				tx_ev_q[EV_TXE] <= 1'b1;
			end
			case (tx_st_q)
				TXS_OFF: if (ctrl_q[CTL_TX_EN]) tx_st_q <= TXS_POLL;
				TXS_POLL: begin
					if (tx_stop_q) begin
						tx_st_q <= TXS_DRAIN;
					end else if (tx_under || tx_un_q) begin
						tx_st_q <= TXS_FAULT;
					end else if (poll_due_q || tx_go_q) begin
						poll_due_q <= 1'b0;
						tx_st_q <= TXS_STAT;
					end
				end
				TXS_STAT: begin
					if (!tx_req_q.valid) begin
						tx_req_q <= '{1'b1, 1'b0, tx_dsc, 16'h0};
					end else if (tx_ack) begin
						tx_req_q.valid <= 1'b0;
						tx_stat_q <= tx_mem_rsp.rdata;
						tx_st_q <= tx_mem_rsp.rdata[D_RDY] ? TXS_LEN : TXS_POLL;
					end
				end
				TXS_LEN: begin
					if (!tx_req_q.valid) begin
						tx_req_q <= '{1'b1, 1'b0, tx_dsc + DSC_LEN, 16'h0};
					end else if (tx_ack) begin
						tx_req_q.valid <= 1'b0;
						tx_len_q <= tx_mem_rsp.rdata;
						tx_st_q <= TXS_PTR;
					end
				end
				TXS_PTR: begin
					if (!tx_req_q.valid) begin
						tx_req_q <= '{1'b1, 1'b0, tx_dsc + DSC_PTR, 16'h0};
					end else if (tx_ack) begin
						tx_req_q.valid <= 1'b0;
						tx_addr_q <= {16'h0, tx_mem_rsp.rdata};
						tx_st_q <= TXS_FETCH;
					end
				end
				TXS_FETCH: begin
					if (tx_req_q.valid) begin
						if (tx_ack) begin
							tx_req_q.valid <= 1'b0;
							tx_addr_q <= tx_addr_q + 32'(tx_npush);
							tx_len_q <= tx_len_q - 16'(tx_npush);
						end
					end else if (tx_stop_q) begin
						tx_st_q <= TXS_DRAIN;
					end else if (tx_un_q || tx_len_q == 16'h0) begin
						tx_st_q <= TXS_CLOSE;
					end else if (tx_room) begin
						tx_req_q <= '{1'b1, 1'b0, {tx_addr_q[31:1], 1'b0}, 16'h0};
					end
				end
				TXS_CLOSE: begin
					if (!tx_req_q.valid) begin
						tx_req_q <= '{1'b1, 1'b1, tx_dsc,
							(tx_stat_q & ~16'h8000) | {6'h0, tx_un_q, 9'h0}};
					end else if (tx_ack) begin
						tx_req_q.valid <= 1'b0;
						tx_ev_q[EV_TXB] <= tx_stat_q[D_INT] & ~tx_un_q;
						tx_idx_q <= tx_stat_q[D_WRAP] ? '0 : tx_idx_q + 1'b1;
						if (tx_un_q)
							tx_st_q <= TXS_FAULT;
						else if (tx_stop_q || tx_stat_q[D_LAST])
							tx_st_q <= TXS_DRAIN;
						else
							tx_st_q <= TXS_STAT;
					end
				end
				TXS_DRAIN: begin
					if (txf_cnt_q == 4'h0 && tx_bit_q == 3'h0) begin
						tx_go_q <= 1'b0;
						tx_st_q <= tx_stop_q ? TXS_STOPPED : TXS_POLL;
					end
				end
				TXS_STOPPED, TXS_FAULT: begin
					if (cmd_q[CMD_RESTART]) begin
						tx_stop_q <= 1'b0;
						tx_un_q <= 1'b0;
						tx_go_q <= 1'b0;
						tx_st_q <= TXS_POLL;
					end
				end
				default: tx_st_q <= TXS_OFF;
			endcase
			if (!ctrl_q[CTL_TX_EN] && !tx_req_q.valid) begin
				tx_st_q <= TXS_OFF;
				tx_go_q <= 1'b0;
				tx_stop_q <= 1'b0;
				tx_un_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// receiver: word shifter, three-word fifo, descriptor engine
	// ------------------------------------------------------------------
	tsc_mem_req_t rx_req_q;
	logic [15:0] rx_stat_q, rx_sh_q, rx_bytes_q;
	logic [31:0] rx_addr_q;
	logic [3:0]  rx_cnt_q;
	logic [15:0] rxf_q [RXF_WORDS];
	logic [1:0]  rxf_wp_q, rxf_rp_q, rxf_cnt_q;
	logic        rx_ov_q, rx_hunt_q, rx_open_q;

	wire [31:0] rx_dsc = rx_base_q + 32'({rx_idx_q, 3'b000});
	wire        rx_ack = rx_req_q.valid & rx_mem_rsp.ack;
	wire        rx_wdone = rx_tick & rx_on_q & (rx_cnt_q == 4'hf);
	wire [15:0] rx_raw = {rx_sh_q[14:0], rx_bit};
	wire [15:0] rx_word = {rev8(rx_raw[15:8], rev), rev8(rx_raw[7:0], rev)};
	wire        rx_full = rxf_cnt_q == RXF_WORDS;
	wire        rx_pop = rx_ack & (rx_st_q == RXS_RUN) & ~rx_mem_rsp.full;
	wire [1:0]  rx_prev = (rxf_wp_q == 2'h0) ? RXF_WORDS - 2'h1 : rxf_wp_q - 2'h1;
	wire [15:0] rx_next = rx_bytes_q + 16'h2;
	wire        rx_end = rx_ov_q | rx_hunt_q;

	assign rx_mem_req = rx_req_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_st_q <= RXS_OFF;
			rx_req_q <= '0;
			rx_idx_q <= '0;
			rx_stat_q <= 16'h0;
			rx_sh_q <= 16'h0;
			rx_bytes_q <= 16'h0;
			rx_addr_q <= 32'h0;
			rx_cnt_q <= 4'h0;
			rxf_wp_q <= 2'h0;
			rxf_rp_q <= 2'h0;
			rxf_cnt_q <= 2'h0;
			rx_ov_q <= 1'b0;
			rx_hunt_q <= 1'b0;
			rx_open_q <= 1'b0;
			rx_on_q <= 1'b0;
			rx_ev_q <= 2'h0;
			for (int i = 0; i < RXF_WORDS; i++) rxf_q[i] <= 16'h0;
		end else begin
			rx_ev_q <= 2'h0;
			if (cmd_q[CMD_HUNT]) rx_hunt_q <= 1'b1;
			if (rx_tick && rx_on_q) begin
				rx_sh_q <= rx_raw;
				rx_cnt_q <= rx_cnt_q + 4'h1;
			end
			if (rx_wdone && rx_full) begin
				rxf_q[rx_prev] <= rx_word;
				rx_ov_q <= 1'b1;
				rx_on_q <= 1'b0;
			end else if (rx_wdone) begin
				rxf_q[rxf_wp_q] <= rx_word;
				rxf_wp_q <= inc3(rxf_wp_q);
			end
			if (rx_pop) rxf_rp_q <= inc3(rxf_rp_q);
			rxf_cnt_q <= rxf_cnt_q + 2'(rx_wdone && !rx_full) - 2'(rx_pop);
			case (rx_st_q)
				RXS_OFF: if (ctrl_q[CTL_RX_EN]) rx_st_q <= RXS_HUNT;
				RXS_HUNT: begin
					rx_hunt_q <= 1'b0;
					if (direct || sync_rise) begin
						rx_on_q <= 1'b1;
						rx_cnt_q <= 4'h0;
						rx_st_q <= rx_open_q ? RXS_RUN : RXS_STAT;
					end
				end
				RXS_STAT: begin
					if (!rx_req_q.valid && rx_hunt_q) begin
						rx_on_q <= 1'b0;
						rx_st_q <= RXS_HUNT;
					end else if (!rx_req_q.valid) begin
						rx_req_q <= '{1'b1, 1'b0, rx_dsc, 16'h0};
					end else if (rx_ack) begin
						rx_req_q.valid <= 1'b0;
						rx_stat_q <= rx_mem_rsp.rdata;
						if (rx_mem_rsp.rdata[D_RDY]) rx_st_q <= RXS_PTR;
					end
				end
				RXS_PTR: begin
					if (!rx_req_q.valid) begin
						rx_req_q <= '{1'b1, 1'b0, rx_dsc + DSC_PTR, 16'h0};
					end else if (rx_ack) begin
						rx_req_q.valid <= 1'b0;
						rx_addr_q <= {16'h0, rx_mem_rsp.rdata};
						rx_bytes_q <= 16'h0;
						rx_open_q <= 1'b1;
						rx_st_q <= RXS_RUN;
					end
				end
				RXS_RUN: begin
					if (rx_req_q.valid) begin
						if (rx_ack && rx_mem_rsp.full) begin
							rx_req_q.valid <= 1'b0;
							rx_ev_q[EV_BSY - 2] <= 1'b1;
							rx_on_q <= 1'b0;
							rx_st_q <= RXS_BUSY;
						end else if (rx_ack) begin
							rx_req_q.valid <= 1'b0;
							rx_addr_q <= rx_addr_q + 32'h2;
							rx_bytes_q <= rx_next;
							if (rx_next >= max_rx_q) rx_st_q <= RXS_LEN;
						end
					end else if (rx_end) begin
						rx_st_q <= RXS_LEN;
					end else if (rxf_cnt_q != 2'h0) begin
						rx_req_q <= '{1'b1, 1'b1, rx_addr_q, rxf_q[rxf_rp_q]};
					end
				end
				RXS_BUSY: if (rx_hunt_q) rx_st_q <= RXS_LEN;
				RXS_LEN: begin
					if (!rx_req_q.valid) begin
						rx_req_q <= '{1'b1, 1'b1, rx_dsc + DSC_LEN, rx_bytes_q};
					end else if (rx_ack) begin
						rx_req_q.valid <= 1'b0;
						rx_st_q <= RXS_CLOSE;
					end
				end
				RXS_CLOSE: begin
					if (!rx_req_q.valid) begin
						rx_req_q <= '{1'b1, 1'b1, rx_dsc,
							(rx_stat_q & ~16'h8000) | {6'h0, rx_ov_q, 9'h0}};
					end else if (rx_ack) begin
						rx_req_q.valid <= 1'b0;
						rx_ev_q[EV_RXB - 2] <= rx_stat_q[D_INT];
						rx_idx_q <= rx_stat_q[D_WRAP] ? '0 : rx_idx_q + 1'b1;
						rx_open_q <= 1'b0;
						rx_st_q <= rx_end ? RXS_HUNT : RXS_STAT;
						if (rx_end) begin
							rx_on_q <= 1'b0;
							rx_ov_q <= 1'b0;
							rxf_cnt_q <= 2'h0;
							rxf_rp_q <= rxf_wp_q;
						end
					end
				end
				default: rx_st_q <= RXS_OFF;
			endcase
			if (!ctrl_q[CTL_RX_EN] && !rx_req_q.valid) begin
				rx_st_q <= RXS_OFF;
				rx_on_q <= 1'b0;
			end
		end
	end
endmodule // tsc_channel

// ### tb/tsc_mem_model.sv
// memory partner: one 16-bit word port, acks one cycle after a request
module tsc_mem_model
	import tsc_pkg::*;
(
	input logic          aclk,
	input tsc_mem_req_t  req,
	output tsc_mem_rsp_t rsp
);
	// cleared so that polls of unprepared descriptors read not-ready
	logic [15:0] m [0:255] = '{default: 16'h0};
	// --------------------------------------------------------------
	// answer
	// --------------------------------------------------------------
	always @(posedge aclk) begin
		rsp.ack <= req.valid && !rsp.ack;
		rsp.full <= 1'b0;
		// idle bus shows a changing pattern, not stale data
		rsp.rdata <= req.valid ? m[req.addr[8:1]] : ~rsp.rdata;
		if (req.valid && rsp.ack && req.we)
			m[req.addr[8:1]] <= req.wdata;
	end
endmodule // tsc_mem_model

// ### tb/tsc_channel_asserts.sv
// checker: port-level assertions of the channel
module tsc_channel_asserts
	import tsc_pkg::*;
(
	input logic         aclk,
	input logic         aresetn,
	input logic         s_axi_awvalid,
	input logic         s_axi_awready,
	input logic         s_axi_wvalid,
	input logic         s_axi_wready,
	input logic         s_axi_bvalid,
	input logic         s_axi_bready,
	input logic         s_axi_arvalid,
	input logic         s_axi_arready,
	input logic [11:0]  s_axi_araddr,
	input logic         s_axi_rvalid,
	input logic [1:0]   s_axi_rresp,
	input logic         txd,
	input tsc_mem_req_t tx_mem_req,
	input tsc_mem_rsp_t tx_mem_rsp,
	input tsc_mem_req_t rx_mem_req
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rd_resp_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read response missing");
	rd_unmapped_a: assert property ((rd_taken and s_axi_araddr == 12'h0fc) |=> s_axi_rresp == 2'b11)
		else $error("unmapped read not refused");
	txd_ones_a: assert property ($rose(aresetn) |-> txd [*3])
		else $error("line not idle after reset");
	req_hold_a: assert property (tx_mem_req.valid && !tx_mem_rsp.ack
		|=> tx_mem_req.valid && $stable(tx_mem_req.addr))
		else $error("fetch request not held");
	ack_drop_a: assert property (tx_mem_rsp.ack |=> !tx_mem_req.valid)
		else $error("fetch request kept after ack");
	tx_word_a: assert property (tx_mem_req.valid |-> !tx_mem_req.addr[0])
		else $error("fetch not word aligned");
	rx_word_a: assert property (rx_mem_req.valid |-> !rx_mem_req.addr[0])
		else $error("store not word aligned");
endmodule // tsc_channel_asserts
bind tsc_channel tsc_channel_asserts u_chk (.*);

// ### tb/tsc_channel_tb.sv
// testbench: descriptor transmit, stop and restart over axi registers
module tsc_channel_tb
	import tsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 0, aresetn = 0, tx_clk = 0, rx_clk = 0, rxd = 1, slot_sync = 0, txd;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h981f35f9, q[$];
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] sh = 16'h0;
	tsc_mem_req_t tx_mem_req, rx_mem_req;
	tsc_mem_rsp_t tx_mem_rsp, rx_mem_rsp;
	int errors = 0, comparisons = 0;
	always #5 aclk = ~aclk;
	always #62.5 tx_clk = ~tx_clk;
	always #62.5 rx_clk = ~rx_clk;
	always @(posedge tx_clk) sh <= {sh[14:0], txd};
	tsc_channel uut (.*);
	tsc_mem_model txm (.aclk(aclk), .req(tx_mem_req), .rsp(tx_mem_rsp));
	tsc_mem_model rxm (.aclk(aclk), .req(rx_mem_req), .rsp(rx_mem_rsp));
	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	function automatic logic [31:0] lf(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
		chk(s_axi_bresp, 32'h0, "bresp");
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge aclk);
		q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 0;
	endtask
	// waits for a bit pattern on the line, msb first
	task automatic see(input logic [15:0] e);
		for (int i = 0; i < 400 && sh !== e; i++)
			@(posedge tx_clk);
		chk(sh, e, "txd");
	endtask
	always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) chk(s_axi_rdata, q.pop_front(), "rdata");
	// --------------------------------------------------------------
	// sequence
	// --------------------------------------------------------------
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		rd(OFS_MAX_RX, 32'h2);
		rd(12'h0fc, 32'h0);
		wr(OFS_ZERO, 32'h0);
		wr(OFS_EVENT, 32'h1f);
		seed = lf(seed);
		txm.m[0] = 16'h9800;
		txm.m[1] = 16'h0002;
		txm.m[2] = 16'h0040;
		txm.m[32] = seed[15:0];
		wr(OFS_TX_BASE, 32'h0);
		wr(OFS_CTRL, 32'h9);
		see(seed[15:0]);
		chk(txm.m[0], 16'h1800, "status");
		rd(OFS_EVENT, 32'h1);
		$display("test single buffer done");
		seed = lf(seed);
		wr(OFS_CMD, 32'h1);
		txm.m[4] = 16'h8800;
		txm.m[5] = 16'h0001;
		txm.m[6] = 16'h0051;
		txm.m[40] = seed[15:0];
		repeat (40) @(posedge tx_clk);
		chk(sh, 16'hffff, "stopped");
		wr(OFS_CMD, 32'h2);
		see({8'hff, seed[7:0]});
		$display("test stop restart done");
		rxm.m[0] = 16'h9000;
		rxm.m[2] = 16'h0020;
		rxm.m[16] = 16'hffff;
		@(posedge aclk);
		rxd <= 0;
		wr(OFS_MAX_RX, 32'h2);
		wr(OFS_CTRL, 32'ha);
		repeat (40) @(posedge rx_clk);
		chk(rxm.m[16], 32'h0, "rx word");
		chk(rxm.m[1], 32'h2, "rx length");
		chk(rxm.m[0], 32'h1000, "rx status");
		rd(OFS_EVENT, 32'h15);
		wr(OFS_CMD, 32'h4);
		$display("test receive done");
		give_verdict();
	end
	initial begin
		#400us;
		errors++;
		give_verdict();
	end
endmodule // tsc_channel_tb
